// ---- logic/fsbp_guard.sv ----
// Protection decoder and program/erase gate for the serial flash array
// Function
// - Scheme select low applies the range-based protection fields.
// - Scheme select high ignores range fields; per-block lock bits decide.
// - Complement flag inverts the decoded region across the whole array.
// - Granularity bit picks 4 kB or 64 kB units for the level.
// - Top/bottom bit grows region down from top or up from zero.
// - Three-bit level chooses none, part or all of the array.
// - Program and erase into the protected region are refused.
// - Plain coarse top: levels 1-3 from 70000/60000/40000, 4-7 whole.
// - Plain coarse bottom: levels 1-3 up to 0FFFF/1FFFF/3FFFF, 4-7 whole.
// - Plain fine top: 7F000/7E000/7C000, 4-5 from 78000, 6-7 whole.
// - Plain fine bottom: to 00FFF/01FFF/03FFF, 4-5 to 07FFF, 6-7 whole.
// - Uncomplemented level zero protects nothing; outside region unprotected.
// - Complemented level zero whole; coarse top levels 1-3 low part, else none.
// - Complemented coarse bottom: levels 1-3 from 10000/20000/40000 upward.
// - Complemented fine top: to 7EFFF/7DFFF/7BFFF, 4-5 to 77FFF.
// - Complemented fine bottom: from 01000/02000/04000, 4-5 from 08000.
// - Complemented fine top levels 1-3: 32 kB erase protects up to 77FFF.
// - Complemented fine top levels 1-5: 64 kB erase protects up to 6FFFF.
// - Complemented fine bottom levels 1-3: 32 kB erase protects from 08000.
// - Complemented fine bottom levels 1-5: 64 kB erase protects from 10000.
`timescale 1ns/1ns
`default_nettype none
`include "fsbp_defs.svh"

module fsbp_guard (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic protection_scheme_select,
  input wire logic complement_protect,
  input wire logic protect_granularity,
  input wire logic top_bottom_select,
  input wire logic [2:0] protect_level_field,
  input wire logic lock_bit_hit,
  input wire logic cmd_valid,
  input wire fsbp_pkg::fsbp_cmd_t cmd_kind,
  input wire logic [23:0] cmd_addr,
  output logic verdict_valid,
  output logic verdict_allow,
  output logic verdict_refuse,
  output logic region_none,
  output logic [18:0] region_lo,
  output logic [18:0] region_hi
);
  import fsbp_pkg::*;

  // Level decode before any complement
  function automatic fsbp_region_t base_region(
    input logic gran,
    input logic bottom,
    input logic [2:0] lvl
  );
    fsbp_region_t r;
    r.none = (lvl == `FSBP_LEVEL_NONE);
    r.lo = `FSBP_ARRAY_BASE;
    r.hi = `FSBP_ARRAY_TOP;
    if (!gran)
    begin
      unique case (lvl)
        3'h1:
        begin
          r.lo = bottom ? `FSBP_ARRAY_BASE : `FSBP_COARSE_TOP_LO1;
          r.hi = bottom ? `FSBP_COARSE_BOT_HI1 : `FSBP_ARRAY_TOP;
        end
        3'h2:
        begin
          r.lo = bottom ? `FSBP_ARRAY_BASE : `FSBP_COARSE_TOP_LO2;
          r.hi = bottom ? `FSBP_COARSE_BOT_HI2 : `FSBP_ARRAY_TOP;
        end
        3'h3:
        begin
          r.lo = bottom ? `FSBP_ARRAY_BASE : `FSBP_COARSE_TOP_LO3;
          r.hi = bottom ? `FSBP_COARSE_BOT_HI3 : `FSBP_ARRAY_TOP;
        end
        default:
        begin
          r.lo = `FSBP_ARRAY_BASE;
          r.hi = `FSBP_ARRAY_TOP;
        end
      endcase
    end
    else
    begin
      unique case (lvl)
        3'h1:
        begin
          r.lo = bottom ? `FSBP_ARRAY_BASE : `FSBP_FINE_TOP_LO1;
          r.hi = bottom ? `FSBP_FINE_BOT_HI1 : `FSBP_ARRAY_TOP;
        end
        3'h2:
        begin
          r.lo = bottom ? `FSBP_ARRAY_BASE : `FSBP_FINE_TOP_LO2;
          r.hi = bottom ? `FSBP_FINE_BOT_HI2 : `FSBP_ARRAY_TOP;
        end
        3'h3:
        begin
          r.lo = bottom ? `FSBP_ARRAY_BASE : `FSBP_FINE_TOP_LO3;
          r.hi = bottom ? `FSBP_FINE_BOT_HI3 : `FSBP_ARRAY_TOP;
        end
        3'h4, 3'h5:
        begin
          r.lo = bottom ? `FSBP_ARRAY_BASE : `FSBP_FINE_TOP_LO4;
          r.hi = bottom ? `FSBP_FINE_BOT_HI4 : `FSBP_ARRAY_TOP;
        end
        default:
        begin
          r.lo = `FSBP_ARRAY_BASE;
          r.hi = `FSBP_ARRAY_TOP;
        end
      endcase
    end
    return r;
  endfunction : base_region

  // Every region touches one end, so its complement stays contiguous
  function automatic fsbp_region_t full_region(
    input logic cmp,
    input logic gran,
    input logic bottom,
    input logic [2:0] lvl
  );
    fsbp_region_t b;
    fsbp_region_t r;
    b = base_region(gran, bottom, lvl);
    r = b;
    if (cmp)
    begin
      if (b.none)
      begin
        r.none = 1'b0;
        r.lo = `FSBP_ARRAY_BASE;
        r.hi = `FSBP_ARRAY_TOP;
      end
      else if (b.lo == `FSBP_ARRAY_BASE && b.hi == `FSBP_ARRAY_TOP)
      begin
        r.none = 1'b1;
      end
      else if (!bottom)
      begin
        r.lo = `FSBP_ARRAY_BASE;
        r.hi = b.lo - 19'h00001;
      end
      else
      begin
        r.lo = b.hi + 19'h00001;
        r.hi = `FSBP_ARRAY_TOP;
      end
    end
    return r;
  endfunction : full_region

  // Large erases see a narrower region under complemented fine settings
  function automatic fsbp_region_t erase_region(
    input logic cmp,
    input logic gran,
    input logic bottom,
    input logic [2:0] lvl,
    input fsbp_cmd_t kind
  );
    fsbp_region_t r;
    r = full_region(cmp, gran, bottom, lvl);
    if (cmp && gran && !r.none)
    begin
      if (kind == FSBP_CMD_ERASE_32K && lvl >= 3'h1 && lvl <= 3'h3)
      begin
        if (!bottom)
          r.hi = `FSBP_E32_TOP_HI;
        else
          r.lo = `FSBP_E32_BOT_LO;
      end
      else if (kind == FSBP_CMD_ERASE_64K && lvl >= 3'h1 && lvl <= 3'h5)
      begin
        if (!bottom)
          r.hi = `FSBP_E64_TOP_HI;
        else
          r.lo = `FSBP_E64_BOT_LO;
      end
    end
    return r;
  endfunction : erase_region

  function automatic logic [18:0] kind_mask(input fsbp_cmd_t kind);
    logic [18:0] m;
    m = 19'h00000;
    unique case (kind)
      FSBP_CMD_PROGRAM: m = 19'h00000;
      FSBP_CMD_ERASE_4K: m = `FSBP_MASK_4K;
      FSBP_CMD_ERASE_32K: m = `FSBP_MASK_32K;
      FSBP_CMD_ERASE_64K: m = `FSBP_MASK_64K;
      FSBP_CMD_ERASE_CHIP: m = `FSBP_ARRAY_TOP;
      default: m = `FSBP_ARRAY_TOP;
    endcase
    return m;
  endfunction : kind_mask

  fsbp_region_t cmd_region;
  logic [18:0] blk_mask;
  logic [18:0] blk_lo;
  logic [18:0] blk_hi;
  logic std_hit;
  logic next_refuse;
  fsbp_region_t view;

  // Upper address bits fold onto the 4-Mbit array
  always_comb
  begin
    cmd_region = erase_region(complement_protect, protect_granularity,
                              top_bottom_select, protect_level_field, cmd_kind);
    blk_mask = kind_mask(cmd_kind);
    blk_lo = cmd_addr[18:0] & ~blk_mask;
    blk_hi = cmd_addr[18:0] | blk_mask;
    std_hit = !cmd_region.none && blk_lo <= cmd_region.hi &&
              blk_hi >= cmd_region.lo;
    if (protection_scheme_select)
      next_refuse = lock_bit_hit;
    else
      next_refuse = std_hit;
    view = full_region(complement_protect, protect_granularity,
                       top_bottom_select, protect_level_field);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      verdict_valid <= 1'b0;
      verdict_allow <= 1'b0;
      verdict_refuse <= 1'b0;
    end
    else
    begin
      verdict_valid <= cmd_valid;
      verdict_allow <= cmd_valid && !next_refuse;
      verdict_refuse <= cmd_valid && next_refuse;
    end
  end

  // Published region is what a program sees; lock scheme shows none
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      region_none <= 1'b1;
      region_lo <= `FSBP_ARRAY_BASE;
      region_hi <= `FSBP_ARRAY_BASE;
    end
    else
    begin
      region_none <= protection_scheme_select || view.none;
      region_lo <= view.lo;
      region_hi <= view.hi;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  logic std_mode;
  assign std_mode = !protection_scheme_select;

  AST_LOCK_SCHEME: assert property (
    protection_scheme_select && cmd_valid |=> verdict_refuse == $past(lock_bit_hit))
    else $error("lock scheme verdict mismatch");

  AST_VERDICT_TIMING: assert property (
    cmd_valid |=> verdict_valid ##1 (verdict_valid == $past(cmd_valid)))
    else $error("verdict not one cycle after command");

  AST_VERDICT_ONEHOT: assert property (
    verdict_valid |-> (verdict_allow ^ verdict_refuse))
    else $error("verdict not exactly one of allow or refuse");

  AST_LEVEL_ZERO: assert property (
    std_mode && !complement_protect && protect_level_field == 3'h0 |=> region_none)
    else $error("level zero should protect nothing");

  AST_CMP_LEVEL_ZERO: assert property (
    std_mode && complement_protect && protect_level_field == 3'h0
    |=> !region_none && region_lo == 19'h00000 && region_hi == 19'h7ffff)
    else $error("complemented level zero should protect all");

  AST_TOP_COARSE_ONE: assert property (
    std_mode && !complement_protect && !protect_granularity && !top_bottom_select &&
    protect_level_field == 3'h1 |=> region_lo == 19'h70000 && region_hi == 19'h7ffff)
    else $error("coarse top level one region wrong");

  AST_BOTTOM_FINE_THREE: assert property (
    std_mode && !complement_protect && protect_granularity && top_bottom_select &&
    protect_level_field == 3'h3 |=> region_lo == 19'h00000 && region_hi == 19'h03fff)
    else $error("fine bottom level three region wrong");

  AST_CMP_HIGH_NONE: assert property (
    std_mode && complement_protect && !protect_granularity &&
    protect_level_field[2] |=> region_none)
    else $error("complemented coarse high level should protect none");

  AST_FULL_REFUSE: assert property (
    cmd_valid && std_mode && !complement_protect && protect_level_field == 3'h7
    |=> verdict_refuse)
    else $error("whole array protected yet command allowed");

  AST_E64_TOP: assert property (
    cmd_valid && std_mode && complement_protect && protect_granularity &&
    !top_bottom_select && protect_level_field == 3'h4 &&
    cmd_kind == FSBP_CMD_ERASE_64K && cmd_addr[18:16] == 3'h7 |=> verdict_allow)
    else $error("top 64 kB erase should pass");

  AST_BOTTOM_COARSE_TWO: assert property (
    std_mode && !complement_protect && !protect_granularity && top_bottom_select &&
    protect_level_field == 3'h2
    |=> !region_none && region_lo == 19'h00000 && region_hi == 19'h1ffff)
    else $error("coarse bottom level two region wrong");

  AST_TOP_FINE_FOUR: assert property (
    std_mode && !complement_protect && protect_granularity && !top_bottom_select &&
    protect_level_field == 3'h4
    |=> !region_none && region_lo == 19'h78000 && region_hi == 19'h7ffff)
    else $error("fine top level four region wrong");

  AST_CMP_TOP_FINE: assert property (
    std_mode && complement_protect && protect_granularity && !top_bottom_select &&
    protect_level_field == 3'h5
    |=> !region_none && region_lo == 19'h00000 && region_hi == 19'h77fff)
    else $error("complemented fine top region wrong");

  AST_CMP_BOTTOM_FINE: assert property (
    std_mode && complement_protect && protect_granularity && top_bottom_select &&
    protect_level_field == 3'h2
    |=> !region_none && region_lo == 19'h02000 && region_hi == 19'h7ffff)
    else $error("complemented fine bottom region wrong");

  AST_E32_BOTTOM: assert property (
    cmd_valid && std_mode && complement_protect && protect_granularity &&
    top_bottom_select && protect_level_field == 3'h3 &&
    cmd_kind == FSBP_CMD_ERASE_32K && cmd_addr[18:15] == 4'h0 |=> verdict_allow)
    else $error("bottom 32 kB erase should pass");

  AST_E32_TOP: assert property (
    cmd_valid && std_mode && complement_protect && protect_granularity &&
    !top_bottom_select && protect_level_field == 3'h1 &&
    cmd_kind == FSBP_CMD_ERASE_32K && cmd_addr[18:15] == 4'hf |=> verdict_allow)
    else $error("top 32 kB erase should pass");

  AST_CHIP_ERASE: assert property (
    cmd_valid && std_mode && !complement_protect && protect_level_field != 3'h0 &&
    cmd_kind == FSBP_CMD_ERASE_CHIP |=> verdict_refuse)
    else $error("chip erase over a protected region allowed");

  CVR_REFUSED: cover property (cmd_valid ##1 verdict_refuse);
  CVR_ALLOWED: cover property (cmd_valid ##1 verdict_allow);
  CVR_LOCKED: cover property (protection_scheme_select && cmd_valid ##1 verdict_refuse);
  CVR_BACK_TO_BACK: cover property (cmd_valid [*2] ##1 verdict_valid);

endmodule : fsbp_guard

`default_nettype wire

// ---- common/fsbp_defs.svh ----
// Constants for the flash standard block protection decoder
`ifndef FSBP_DEFS_SVH
`define FSBP_DEFS_SVH

`define FSBP_ARRAY_AW 19
`define FSBP_ARRAY_TOP 19'h7ffff
`define FSBP_ARRAY_BASE 19'h00000

`define FSBP_COARSE_TOP_LO1 19'h70000
`define FSBP_COARSE_TOP_LO2 19'h60000
`define FSBP_COARSE_TOP_LO3 19'h40000
`define FSBP_COARSE_BOT_HI1 19'h0ffff
`define FSBP_COARSE_BOT_HI2 19'h1ffff
`define FSBP_COARSE_BOT_HI3 19'h3ffff

`define FSBP_FINE_TOP_LO1 19'h7f000
`define FSBP_FINE_TOP_LO2 19'h7e000
`define FSBP_FINE_TOP_LO3 19'h7c000
`define FSBP_FINE_TOP_LO4 19'h78000
`define FSBP_FINE_BOT_HI1 19'h00fff
`define FSBP_FINE_BOT_HI2 19'h01fff
`define FSBP_FINE_BOT_HI3 19'h03fff
`define FSBP_FINE_BOT_HI4 19'h07fff

`define FSBP_E32_TOP_HI 19'h77fff
`define FSBP_E64_TOP_HI 19'h6ffff
`define FSBP_E32_BOT_LO 19'h08000
`define FSBP_E64_BOT_LO 19'h10000

`define FSBP_MASK_4K 19'h00fff
`define FSBP_MASK_32K 19'h07fff
`define FSBP_MASK_64K 19'h0ffff

`define FSBP_LEVEL_NONE 3'h0

`endif

// ---- common/fsbp_pkg.sv ----
// Types for the flash standard block protection decoder
`default_nettype none

package fsbp_pkg;

  typedef enum logic [2:0] {
    FSBP_CMD_PROGRAM,
    FSBP_CMD_ERASE_4K,
    FSBP_CMD_ERASE_32K,
    FSBP_CMD_ERASE_64K,
    FSBP_CMD_ERASE_CHIP
  } fsbp_cmd_t;

  typedef struct packed {
    logic none;
    logic [18:0] lo;
    logic [18:0] hi;
  } fsbp_region_t;

endpackage : fsbp_pkg

`default_nettype wire

// ---- tb/fsbp_host_model.sv ----
// Host controller model that issues program and erase commands
`timescale 1ns/1ns
`default_nettype none

module fsbp_host_model (
  input wire logic sys_clk,
  output logic cmd_valid,
  output fsbp_pkg::fsbp_cmd_t cmd_kind,
  output logic [23:0] cmd_addr,
  output logic lock_bit_hit
);
  import fsbp_pkg::*;
  initial
  begin
    cmd_valid = 1'h0;
    cmd_kind = FSBP_CMD_PROGRAM;
    cmd_addr = 24'h0;
    lock_bit_hit = 1'h0;
  end
  // Idle cycles invert address, so a stale value never passes
  task automatic issue(input logic v, input fsbp_cmd_t k, input logic [23:0] a, input logic h);
    @(posedge sys_clk);
    cmd_valid <= v;
    cmd_kind <= k;
    cmd_addr <= v ? a : ~cmd_addr;
    lock_bit_hit <= v ? h : ~lock_bit_hit;
  endtask : issue
endmodule : fsbp_host_model

`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the protection decoder
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import fsbp_pkg::*;
  typedef struct packed {logic [6:0] c; fsbp_cmd_t k; logic [23:0] a; logic [1:0] hr;} fsbp_row_t;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic sch = 1'h0, cmp = 1'h0, gran = 1'h0, bot = 1'h0;
  logic [2:0] lvl = 3'h0;
  logic cmd_valid, lock_bit_hit, verdict_valid, verdict_allow, verdict_refuse, region_none;
  fsbp_cmd_t cmd_kind;
  logic [23:0] cmd_addr;
  logic [18:0] region_lo, region_hi;
  int fail_count = 0;
  int n_tests = 0;
  logic pend = 1'h0, okr = 1'h0, exp_ref = 1'h0;
  fsbp_region_t exp_reg;
  fsbp_row_t rows [16] = '{
    '{7'h31, FSBP_CMD_ERASE_32K, 24'h078000, 2'h0}, '{7'h31, FSBP_CMD_PROGRAM, 24'h078000, 2'h1},
    '{7'h31, FSBP_CMD_ERASE_4K, 24'h07f000, 2'h0}, '{7'h31, FSBP_CMD_ERASE_32K, 24'h070000, 2'h1},
    '{7'h35, FSBP_CMD_ERASE_64K, 24'h070000, 2'h0}, '{7'h35, FSBP_CMD_ERASE_64K, 24'h06ffff, 2'h1},
    '{7'h3b, FSBP_CMD_ERASE_32K, 24'h007fff, 2'h0}, '{7'h3b, FSBP_CMD_ERASE_4K, 24'h004000, 2'h1},
    '{7'h3c, FSBP_CMD_ERASE_64K, 24'h00ffff, 2'h0}, '{7'h3c, FSBP_CMD_PROGRAM, 24'h008000, 2'h1},
    '{7'h01, FSBP_CMD_PROGRAM, 24'h06ffff, 2'h0}, '{7'h01, FSBP_CMD_ERASE_CHIP, 24'h0, 2'h1},
    '{7'h00, FSBP_CMD_ERASE_CHIP, 24'h0, 2'h0}, '{7'h47, FSBP_CMD_PROGRAM, 24'h0, 2'h0},
    '{7'h47, FSBP_CMD_PROGRAM, 24'h0, 2'h3}, '{7'h01, FSBP_CMD_PROGRAM, 24'hf70000, 2'h1}};
  logic [23:0] probe [16] = '{24'h0, 24'h0fff, 24'h1000, 24'h7fff, 24'h8000, 24'hffff,
    24'h10000, 24'h3ffff, 24'h40000, 24'h6ffff, 24'h77fff, 24'h7c000, 24'h7efff,
    24'h7f000, 24'h7ffff, 24'hf80000};

  always #4 sys_clk = ~sys_clk;

  fsbp_host_model host (.sys_clk(sys_clk), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
    .cmd_addr(cmd_addr), .lock_bit_hit(lock_bit_hit));

  fsbp_guard dut (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .protection_scheme_select(sch),
    .complement_protect(cmp),
    .protect_granularity(gran),
    .top_bottom_select(bot),
    .protect_level_field(lvl),
    .lock_bit_hit(lock_bit_hit),
    .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind),
    .cmd_addr(cmd_addr),
    .verdict_valid(verdict_valid),
    .verdict_allow(verdict_allow),
    .verdict_refuse(verdict_refuse),
    .region_none(region_none),
    .region_lo(region_lo),
    .region_hi(region_hi)
  );

  // Region as a size at the chosen end, then complemented if asked
  function automatic fsbp_region_t exp_region(input logic [6:0] c, input fsbp_cmd_t k);
    fsbp_region_t r;
    logic [19:0] sz;
    logic [2:0] l;
    l = c[2:0];
    if (l == 3'h0)
      sz = 20'h0;
    else if (!c[4])
      sz = (l > 3'h3) ? 20'h80000 : 20'h10000 << (l - 3'h1);
    else
      sz = (l > 3'h5) ? 20'h80000 : 20'h1000 << ((l > 3'h3) ? 3'h3 : l - 3'h1);
    if (c[5] && c[4] && k == FSBP_CMD_ERASE_32K && l != 3'h0 && l < 3'h4)
      sz = 20'h8000;
    if (c[5] && c[4] && k == FSBP_CMD_ERASE_64K && l != 3'h0 && l < 3'h6)
      sz = 20'h10000;
    if (c[5])
    begin
      r.none = (sz == 20'h80000);
      r.lo = c[3] ? sz[18:0] : 19'h0;
      r.hi = c[3] ? 19'h7ffff : 19'(20'h7ffff - sz);
    end
    else
    begin
      r.none = (sz == 20'h0);
      r.lo = c[3] ? 19'h0 : 19'(20'h80000 - sz);
      r.hi = c[3] ? 19'(sz - 20'h1) : 19'h7ffff;
    end
    r.none = r.none | c[6];
    return r;
  endfunction : exp_region

  function automatic logic refuse(input fsbp_region_t e, input fsbp_cmd_t k, input logic [18:0] a);
    logic [18:0] m;
    case (k)
      FSBP_CMD_PROGRAM: m = 19'h0;
      FSBP_CMD_ERASE_4K: m = 19'hfff;
      FSBP_CMD_ERASE_32K: m = 19'h7fff;
      FSBP_CMD_ERASE_64K: m = 19'hffff;
      default: m = 19'h7ffff;
    endcase
    return !e.none && (a & ~m) <= e.hi && (a | m) >= e.lo;
  endfunction : refuse

  task automatic miss(input string s);
    fail_count++;
    $display("mismatch at %0t: %s", $time, s);
  endtask : miss

  task automatic cmp_verdict(input logic v, input logic r);
    n_tests++;
    if ({verdict_valid, verdict_refuse, verdict_allow} !== {v, v & r, v & ~r})
      miss("verdict");
  endtask : cmp_verdict

  task automatic cmp_region(input fsbp_region_t e, input logic all);
    n_tests++;
    if (region_none !== e.none || ((all || !e.none) && {region_lo, region_hi} !== {e.lo, e.hi}))
      miss("region");
  endtask : cmp_region

  // One command per edge; checks the one taken an edge earlier
  task automatic send(input logic [6:0] c, input logic v, input fsbp_cmd_t k,
                      input logic [23:0] a, input logic h, input logic r);
    host.issue(v, k, a, h);
    {sch, cmp, gran, bot, lvl} <= c;
    @(negedge sys_clk);
    cmp_verdict(pend, exp_ref);
    if (okr)
      cmp_region(exp_reg, 1'h0);
    pend = v;
    exp_ref = r;
    exp_reg = exp_region(c, FSBP_CMD_PROGRAM);
    okr = 1'h1;
  endtask : send

  task automatic chk_reset;
    cmp_verdict(1'h0, 1'h0);
    cmp_region('{1'h1, 19'h0, 19'h0}, 1'h1);
    pend = 1'h0;
    okr = 1'h0;
  endtask : chk_reset

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  initial
  begin
    logic [6:0] c;
    repeat (7) @(posedge sys_clk);
    @(negedge sys_clk);
    chk_reset();
    @(posedge sys_clk);
    rst_n <= 1'h1;
    foreach (rows[i])
      send(rows[i].c, 1'h1, rows[i].k, rows[i].a, rows[i].hr[1], rows[i].hr[0]);
    // Back-to-back sweep of every setting, kind and boundary probe
    for (int s = 0; s < 128; s++)
      for (int k = 0; k < 5; k++)
        foreach (probe[p])
        begin
          c = 7'(s);
          send(c, 1'h1, fsbp_cmd_t'(k), probe[p], p[0], c[6] ? p[0]
               : refuse(exp_region(c, fsbp_cmd_t'(k)), fsbp_cmd_t'(k), probe[p][18:0]));
        end
    // Idle first, so no command is sampled as reset lifts
    send(7'h00, 1'h0, FSBP_CMD_PROGRAM, 24'h0, 1'h0, 1'h0);
    @(posedge sys_clk);
    rst_n <= 1'h0;
    @(negedge sys_clk);
    chk_reset();
    @(posedge sys_clk);
    rst_n <= 1'h1;
    send(7'h01, 1'h1, FSBP_CMD_PROGRAM, 24'h07ffff, 1'h0, 1'h1);
    send(7'h01, 1'h0, FSBP_CMD_PROGRAM, 24'h0, 1'h0, 1'h0);
    send(7'h01, 1'h0, FSBP_CMD_PROGRAM, 24'h0, 1'h0, 1'h0);
    close_out();
  end
endmodule : tb_top

`default_nettype wire
